/* core/hdpm_master.sv */
// half-duplex poll master: register slave, poll sequencer, modem timing and reply timer
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "hdpm_params.svh"
module hdpm_master import hdpm_pkg::*; #(
   parameter int TICK_CYCLES = `HDPM_TICK_CYCLES,
   parameter int LIST_DEPTH  = 64
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // axi4-lite write
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // modem
   output logic             rts,
   input  wire logic        cts,
   // frame engine
   output logic             frmStart,
   output logic             frmPoll,
   output logic [7:0]       frmDest,
   output logic             txGate,
   input  wire logic        frmDone,
   input  wire logic        rxAck,
   input  wire logic        rxEot,
   input  wire logic        rxData,
   input  wire logic        rxReply,
   input  wire logic [7:0]  rxSrc
);
   localparam int       IW     = $clog2(LIST_DEPTH);
   localparam bit [7:0] MAXOFF = 8'(LIST_DEPTH - `HDPM_LIST_FIRST);

   hdpm_live_if lv ();
   hdpm_state_t state;
   logic        tick;
   logic [7:0]  ownAddr, retryLimit, rtsOnDelay, rtsOffDelay, ackTimeout;
   logic [7:0]  replyWait, replyCompletionLimit, groupCount;
   logic [1:0]  pollMode;
   logic        txInSeq, enable;
   logic [7:0]  normList [LIST_DEPTH];
   logic [7:0]  prioList [LIST_DEPTH];
   logic        msgPending, undeliverable, replyErr, awaitReply;
   logic [7:0]  msgDest;
   logic        wrFire, badWrite, msgLoad, rdErr;
   logic [31:0] wd, rdMux, w1c;
   logic [7:0]  cnt, tries, curDest, normOff, prioOff, groupLeft;
   logic        curPoll, inPrio, afterPoll, msgDoneStb, msgFailStb, ackStb;
   logic [7:0]  prioNext, normNext;
   logic [18:0] replyCnt;

   hdpm_tick #(.CYCLES(TICK_CYCLES)) uTick (.clk(clk), .resetn(resetn), .tick(tick));
   hdpm_live_store uLive (.clk(clk), .resetn(resetn), .lv(lv.store));

   // write taken when both channels meet the raised readies
   assign wrFire  = awvalid && wvalid && awready && wready;
   assign wd      = wdata;
   assign msgLoad = wrFire && !badWrite && awaddr == `HDPM_OFF_MSG;
   assign w1c     = (wrFire && awaddr == `HDPM_OFF_STATUS) ? wd : 32'h0;
   assign prioNext = prioList[IW'(prioOff + 8'h02)];
   assign normNext = normList[IW'(normOff + 8'h02)];
   assign lv.rdIdx   = araddr[4:2];
   assign lv.bitAddr = (state == HDPM_PICK) ? normNext : curDest;

   // write checks: bad addresses, full message slot, unmapped offsets
   always_comb begin
      badWrite = 1'b0;
      if (awaddr[11:8] == `HDPM_NORM_PAGE || awaddr[11:8] == `HDPM_PRIO_PAGE) begin
         if (awaddr[7:2] == 6'h00) begin
            badWrite = wd[7:0] > MAXOFF;
         end else if (awaddr[7:2] >= 6'h02) begin
            badWrite = wd[7:0] == `HDPM_ADDR_BCAST || awaddr[7:2] > 6'(LIST_DEPTH - 1);
         end
      end else begin
         unique case (awaddr)
            `HDPM_OFF_CTRL: badWrite = wd[7:0] > `HDPM_ADDR_MAX;
            `HDPM_OFF_MSG: badWrite = msgPending;
            `HDPM_OFF_RETRY, `HDPM_OFF_RTSON, `HDPM_OFF_RTSOFF, `HDPM_OFF_ACKTO,
            `HDPM_OFF_RWAIT, `HDPM_OFF_RLIMIT, `HDPM_OFF_GROUP, `HDPM_OFF_STATUS: badWrite = 1'b0;
            default: badWrite = 1'b1;
         endcase
      end
   end

   // axi write handshake: readies pulse together, response after the write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= 2'h0;
      end else begin
         awready <= awvalid && wvalid && !awready && !bvalid;
         wready  <= awvalid && wvalid && !awready && !bvalid;
         if (wrFire) begin
            bvalid <= 1'b1;
            bresp  <= badWrite ? 2'h2 : 2'h0;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ownAddr              <= `HDPM_RST_OWN;
         retryLimit           <= `HDPM_RST_RETRY;
         rtsOnDelay           <= `HDPM_RST_ZERO;
         rtsOffDelay          <= `HDPM_RST_ZERO;
         ackTimeout           <= `HDPM_RST_ACKTO;
         replyWait            <= `HDPM_RST_ZERO;
         replyCompletionLimit <= `HDPM_RST_ZERO;
         groupCount           <= `HDPM_RST_GROUP;
         pollMode             <= 2'h0;
         txInSeq              <= 1'b0;
         enable               <= 1'b0;
      end else if (wrFire && !badWrite && wstrb[1:0] == 2'h3) begin
         unique case (awaddr)
            `HDPM_OFF_CTRL: begin
               ownAddr  <= wd[7:0];
               pollMode <= wd[`HDPM_CTRL_MODE_LSB +: 2];
               txInSeq  <= wd[`HDPM_CTRL_SEQ_BIT];
               enable   <= wd[`HDPM_CTRL_EN_BIT];
            end
            `HDPM_OFF_RETRY:  retryLimit           <= wd[7:0];
            `HDPM_OFF_RTSON:  rtsOnDelay           <= wd[7:0];
            `HDPM_OFF_RTSOFF: rtsOffDelay          <= wd[7:0];
            `HDPM_OFF_ACKTO:  ackTimeout           <= wd[7:0];
            `HDPM_OFF_RWAIT:  replyWait            <= wd[7:0];
            `HDPM_OFF_RLIMIT: replyCompletionLimit <= wd[7:0];
            `HDPM_OFF_GROUP:  groupCount           <= wd[7:0];
            default: ;
         endcase
      end
   end

   // poll lists: entry 0 count, entry 1 kept by the sequencer, addresses from entry 2
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < LIST_DEPTH; i++) begin
            normList[i] <= 8'h00;
            prioList[i] <= 8'h00;
         end
      end else if (wrFire && !badWrite && wstrb[0] && awaddr[7:2] != 6'h01) begin
         if (awaddr[11:8] == `HDPM_NORM_PAGE) begin
            normList[IW'(awaddr[7:2])] <= wd[7:0];
         end else if (awaddr[11:8] == `HDPM_PRIO_PAGE) begin
            prioList[IW'(awaddr[7:2])] <= wd[7:0];
         end
      end
   end

   // outbound message slot and sticky status; a set beats a clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         msgPending    <= 1'b0;
         msgDest       <= 8'h00;
         undeliverable <= 1'b0;
      end else begin
         if (msgLoad) begin
            msgPending <= 1'b1;
            msgDest    <= wd[7:0];
         end else if (msgDoneStb) begin
            msgPending <= 1'b0;
         end
         if (msgFailStb) begin
            undeliverable <= 1'b1;
         end else if (w1c[`HDPM_STAT_UNDEL_BIT]) begin
            undeliverable <= 1'b0;
         end
      end
   end

   // reply timer in 30 s units from the ack
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         replyCnt   <= 19'h0;
         awaitReply <= 1'b0;
         replyErr   <= 1'b0;
      end else begin
         if (tick && replyCnt != 19'h0) begin
            replyCnt <= replyCnt - 19'h1;
         end
         if (ackStb) begin
            awaitReply <= 1'b1;
            replyCnt   <= 19'(replyCompletionLimit * `HDPM_REPLY_UNIT_TICKS);
         end else if (awaitReply && rxReply && rxSrc == msgDest) begin
            awaitReply <= 1'b0;
         end else if (awaitReply && replyCnt == 19'h0) begin
            awaitReply <= 1'b0;
         end
         if (awaitReply && !ackStb && replyCnt == 19'h0 && !(rxReply && rxSrc == msgDest)) begin
            replyErr <= 1'b1;
         end else if (w1c[`HDPM_STAT_RERR_BIT]) begin
            replyErr <= 1'b0;
         end
      end
   end

   // register read mux
   always_comb begin
      rdMux = 32'h0;
      rdErr = 1'b0;
      if (araddr[11:5] == `HDPM_LIVE_PAGE) begin
         rdMux = lv.rdData;
      end else if (araddr[11:8] == `HDPM_NORM_PAGE || araddr[11:8] == `HDPM_PRIO_PAGE) begin
         if (araddr[7:2] > 6'(LIST_DEPTH - 1)) begin
            rdErr = 1'b1;
         end else if (araddr[7:2] == 6'h01) begin
            rdMux[7:0] = (araddr[11:8] == `HDPM_NORM_PAGE) ? normOff : prioOff;
         end else begin
            rdMux[7:0] = (araddr[11:8] == `HDPM_NORM_PAGE) ? normList[IW'(araddr[7:2])]
                                                           : prioList[IW'(araddr[7:2])];
         end
      end else begin
         unique case (araddr)
            `HDPM_OFF_CTRL:   rdMux = {20'h0, enable, txInSeq, pollMode, ownAddr};
            `HDPM_OFF_RETRY:  rdMux[7:0] = retryLimit;
            `HDPM_OFF_RTSON:  rdMux[7:0] = rtsOnDelay;
            `HDPM_OFF_RTSOFF: rdMux[7:0] = rtsOffDelay;
            `HDPM_OFF_ACKTO:  rdMux[7:0] = ackTimeout;
            `HDPM_OFF_RWAIT:  rdMux[7:0] = replyWait;
            `HDPM_OFF_RLIMIT: rdMux[7:0] = replyCompletionLimit;
            `HDPM_OFF_GROUP:  rdMux[7:0] = groupCount;
            `HDPM_OFF_MSG:    rdMux[7:0] = msgDest;
            `HDPM_OFF_STATUS: rdMux[3:0] = {awaitReply, replyErr, undeliverable, msgPending};
            default:          rdErr = 1'b1;
         endcase
      end
   end

   // axi read handshake
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= 2'h0;
      end else begin
         arready <= arvalid && !arready && !rvalid;
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rdMux;
            rresp  <= rdErr ? 2'h2 : 2'h0;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // poll sequencer with modem timing; counters load on entry and run on the tick
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state      <= HDPM_IDLE;
         cnt        <= 8'h00;
         tries      <= 8'h00;
         curDest    <= 8'h00;
         curPoll    <= 1'b0;
         inPrio     <= 1'b1;
         normOff    <= 8'h00;
         prioOff    <= 8'h00;
         groupLeft  <= 8'h00;
         afterPoll  <= 1'b0;
         rts        <= 1'b0;
         frmStart   <= 1'b0;
         frmPoll    <= 1'b0;
         frmDest    <= 8'h00;
         txGate     <= 1'b0;
         msgDoneStb <= 1'b0;
         msgFailStb <= 1'b0;
         ackStb     <= 1'b0;
         lv.wrEn    <= 1'b0;
         lv.wrAddr  <= 8'h00;
         lv.wrVal   <= 1'b0;
      end else begin
         frmStart   <= 1'b0;
         msgDoneStb <= 1'b0;
         msgFailStb <= 1'b0;
         ackStb     <= 1'b0;
         lv.wrEn    <= 1'b0;
         if (tick && cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end
         unique case (state)
            HDPM_IDLE: if (enable) state <= HDPM_PICK;
            HDPM_PICK: begin
               tries <= 8'h00;
               if (!enable) begin
                  state <= HDPM_IDLE;
               end else if (msgPending && !txInSeq && afterPoll) begin
                  afterPoll <= 1'b0;
                  curPoll   <= 1'b0;
                  curDest   <= msgDest;
                  rts       <= 1'b1;
                  cnt       <= rtsOnDelay;
                  state     <= HDPM_RTS_ON;
               end else if (inPrio) begin
                  if (prioOff < prioList[0]) begin
                     prioOff <= prioOff + 8'h01;
                     if (prioNext != ownAddr || (txInSeq && msgPending)) begin
                        curPoll <= prioNext != ownAddr;
                        curDest <= (prioNext == ownAddr) ? msgDest : prioNext;
                        rts     <= 1'b1;
                        cnt     <= rtsOnDelay;
                        state   <= HDPM_RTS_ON;
                     end
                  end else begin
                     inPrio    <= 1'b0;
                     groupLeft <= groupCount;
                  end
               end else if (groupLeft == 8'h00 || normOff >= normList[0]) begin
                  inPrio  <= 1'b1;
                  prioOff <= 8'h00;
                  if (normOff >= normList[0]) normOff <= 8'h00;
               end else begin
                  normOff <= normOff + 8'h01;
                  if (normNext != ownAddr) begin
                     if (lv.bitVal) groupLeft <= groupLeft - 8'h01;
                     curPoll <= 1'b1;
                     curDest <= normNext;
                     rts     <= 1'b1;
                     cnt     <= rtsOnDelay;
                     state   <= HDPM_RTS_ON;
                  end else if (txInSeq && msgPending) begin
                     curPoll <= 1'b0;
                     curDest <= msgDest;
                     rts     <= 1'b1;
                     cnt     <= rtsOnDelay;
                     state   <= HDPM_RTS_ON;
                  end
               end
            end
            HDPM_RTS_ON: if (cnt == 8'h00 && cts) begin
               frmStart <= 1'b1;
               frmPoll  <= curPoll;
               frmDest  <= curDest;
               txGate   <= 1'b1;
               state    <= HDPM_SEND;
            end
            HDPM_SEND: begin
               txGate <= cts;
               if (frmDone) begin
                  txGate <= 1'b0;
                  cnt    <= rtsOffDelay;
                  state  <= HDPM_RTS_OFF;
               end
            end
            HDPM_RTS_OFF: if (cnt == 8'h00) begin
               rts   <= 1'b0;
               cnt   <= ackTimeout;
               state <= HDPM_WAIT;
            end
            HDPM_WAIT: begin
               if (curPoll && (rxData || rxEot) && rxSrc == curDest) begin
                  lv.wrEn   <= 1'b1;
                  lv.wrAddr <= curDest;
                  lv.wrVal  <= 1'b1;
                  if (rxData && pollMode == HDPM_MULTI) begin
                     tries <= 8'h00;
                     rts   <= 1'b1;
                     cnt   <= rtsOnDelay;
                     state <= HDPM_RTS_ON;
                  end else begin
                     afterPoll <= 1'b1;
                     state     <= HDPM_PICK;
                  end
               end else if (!curPoll && rxAck) begin
                  msgDoneStb <= 1'b1;
                  ackStb     <= 1'b1;
                  if (pollMode == HDPM_MSGB) begin
                     cnt   <= replyWait;
                     state <= HDPM_RWAIT;
                  end else begin
                     state <= HDPM_PICK;
                  end
               end else if (cnt == 8'h00) begin
                  if (tries < retryLimit) begin
                     tries <= tries + 8'h01;
                     rts   <= 1'b1;
                     cnt   <= rtsOnDelay;
                     state <= HDPM_RTS_ON;
                  end else begin
                     state <= HDPM_PICK;
                     if (curPoll) begin
                        afterPoll <= 1'b1;
                        lv.wrEn   <= lv.bitVal;
                        lv.wrAddr <= curDest;
                        lv.wrVal  <= 1'b0;
                     end else begin
                        msgFailStb <= 1'b1;
                        msgDoneStb <= 1'b1;
                     end
                  end
               end
            end
            HDPM_RWAIT: if (cnt == 8'h00) begin
               curPoll <= 1'b1;
               tries   <= 8'h00;
               rts     <= 1'b1;
               cnt     <= rtsOnDelay;
               state   <= HDPM_RTS_ON;
            end
            default: state <= HDPM_IDLE;
         endcase
      end
   end
endmodule : hdpm_master

/* inc/hdpm_params.svh */
// constants of the half-duplex poll master: timing, offsets, fields and reset values
`ifndef HDPM_PARAMS_SVH
`define HDPM_PARAMS_SVH
`define HDPM_CLK_MHZ          200
`define HDPM_TICK_MS          20
`define HDPM_TICK_CYCLES      (`HDPM_TICK_MS * 1000 * `HDPM_CLK_MHZ)
`define HDPM_REPLY_UNIT_MS    30000
`define HDPM_REPLY_UNIT_TICKS (`HDPM_REPLY_UNIT_MS / `HDPM_TICK_MS)
`define HDPM_ADDR_MAX         8'hFE
`define HDPM_ADDR_BCAST       8'hFF
`define HDPM_LIST_FIRST       2
`define HDPM_OFF_CTRL         12'h000
`define HDPM_OFF_RETRY        12'h004
`define HDPM_OFF_RTSON        12'h008
`define HDPM_OFF_RTSOFF       12'h00C
`define HDPM_OFF_ACKTO        12'h010
`define HDPM_OFF_RWAIT        12'h014
`define HDPM_OFF_RLIMIT       12'h018
`define HDPM_OFF_GROUP        12'h01C
`define HDPM_OFF_MSG          12'h020
`define HDPM_OFF_STATUS       12'h024
`define HDPM_LIVE_PAGE        7'h02
`define HDPM_NORM_PAGE        4'h1
`define HDPM_PRIO_PAGE        4'h2
`define HDPM_CTRL_MODE_LSB    8
`define HDPM_CTRL_SEQ_BIT     10
`define HDPM_CTRL_EN_BIT      11
`define HDPM_STAT_PEND_BIT    0
`define HDPM_STAT_UNDEL_BIT   1
`define HDPM_STAT_RERR_BIT    2
`define HDPM_STAT_AWAIT_BIT   3
`define HDPM_RST_OWN          8'h00
`define HDPM_RST_RETRY        8'h03
`define HDPM_RST_ACKTO        8'h0A
`define HDPM_RST_GROUP        8'h01
`define HDPM_RST_ZERO         8'h00
`endif

/* inc/hdpm_pkg.sv */
// types of the half-duplex poll master
package hdpm_pkg;
   typedef enum logic [2:0] {
      HDPM_IDLE = 3'b000, HDPM_PICK = 3'b001, HDPM_RTS_ON = 3'b011, HDPM_SEND = 3'b010,
      HDPM_RTS_OFF = 3'b110, HDPM_WAIT = 3'b111, HDPM_RWAIT = 3'b101
   } hdpm_state_t;
   typedef enum logic [1:0] {HDPM_SINGLE = 2'h0, HDPM_MULTI = 2'h1, HDPM_MSGB = 2'h2} hdpm_mode_t;
endpackage : hdpm_pkg

/* inc/hdpm_live_if.sv */
// liveness bitmap access between the sequencer and the bitmap store
`timescale 1ns/100ps
interface hdpm_live_if;
   logic        wrEn;
   logic [7:0]  wrAddr;
   logic        wrVal;
   logic [2:0]  rdIdx;
   logic [31:0] rdData;
   logic [7:0]  bitAddr;
   logic        bitVal;
   modport owner (output wrEn, wrAddr, wrVal, rdIdx, bitAddr, input rdData, bitVal);
   modport store (input wrEn, wrAddr, wrVal, rdIdx, bitAddr, output rdData, bitVal);
endinterface : hdpm_live_if

/* core/hdpm_tick.sv */
// shared 20 ms tick divider
`timescale 1ns/100ps
module hdpm_tick #(
   parameter int CYCLES = 4000000
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // tick out
   output logic      tick
);
   logic [31:0] count;

   // count down and pulse once per period
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= 32'h0;
         tick  <= 1'b0;
      end else if (count == 32'h0) begin
         count <= 32'(CYCLES - 1);
         tick  <= 1'b1;
      end else begin
         count <= count - 32'h1;
         tick  <= 1'b0;
      end
   end
endmodule : hdpm_tick

/* core/hdpm_live_store.sv */
// per-station liveness bitmap, station 0 at bit 0 of word 0
`timescale 1ns/100ps
module hdpm_live_store (
   // clock and reset
   input  wire logic  clk,
   input  wire logic  resetn,
   // bitmap access
   hdpm_live_if.store lv
);
   logic [31:0] word [8];

   // one bit per station, 1 active, 0 inactive
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 8; i++) begin
            word[i] <= 32'h0;
         end
      end else if (lv.wrEn) begin
         word[lv.wrAddr[7:5]][lv.wrAddr[4:0]] <= lv.wrVal;
      end
   end

   // word and bit reads
   assign lv.rdData = word[lv.rdIdx];
   assign lv.bitVal = word[lv.bitAddr[7:5]][lv.bitAddr[4:0]];
endmodule : hdpm_live_store

/* dv/hdpm_master_checker.sv */
// port checker for the poll master
`timescale 1ns/100ps
module hdpm_master_checker (
   // clock and reset
   input wire logic        clk, resetn,
   // register bus
   input wire logic        awready, wready, bvalid, rvalid, rready,
   input wire logic [31:0] rdata,
   // link
   input wire logic        rts, cts, txGate, frmStart, frmPoll, frmDone,
   input wire logic [7:0]  frmDest
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   start_cause_a: assert property (frmStart |-> $past(rts) && $past(cts))
      else $error("start without rts");
   start_gate_a: assert property (frmStart |-> txGate && rts)
      else $error("start without gate");
   gate_cts_a: assert property (txGate |-> $past(cts))
      else $error("gate without cts");
   rts_hold_a: assert property (frmDone && rts |=> rts)
      else $error("rts cut at end");
   rts_drop_a: assert property ($fell(rts) |-> !txGate && !$past(txGate))
      else $error("rts cut in frame");
   poll_dest_a: assert property (frmStart && frmPoll |-> frmDest != 8'hFF)
      else $error("broadcast poll");
   wr_answer_a: assert property (awready |-> wready ##1 (bvalid && !awready))
      else $error("write unanswered");
   r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer moved");
endmodule : hdpm_master_checker
bind hdpm_master hdpm_master_checker chk (.clk, .resetn, .awready, .wready, .bvalid, .rvalid, .rready,
   .rdata, .rts, .cts, .txGate, .frmStart, .frmPoll, .frmDone, .frmDest);

/* dv/hdpm_slave_model.sv */
// modem, frame engine and slave stations facing the poll master
`timescale 1ns/100ps
module hdpm_slave_model (
   // from master
   input  wire logic       clk, rts, frmStart, frmPoll, txGate, mute,
   input  wire logic [7:0] frmDest,
   // to master
   output logic            cts = 0, frmDone = 0, rxAck = 0, rxEot = 0, rxData = 0, rxReply = 0,
   output logic [7:0]      rxSrc = 0
);
   logic [2:0] cnt = 0;
   logic       owed = 0;
   // cts one cycle after rts, four characters a frame, answer once rts is down
   always @(posedge clk) begin
      cts <= rts;
      {frmDone, rxAck, rxEot} <= 0;
      rxSrc <= ~rxSrc; // source flips to its complement each cycle between answers
      if (frmStart) cnt <= 4;
      else if (txGate && cnt != 0) {cnt, frmDone, owed} <= {cnt - 3'h1, cnt == 1, cnt == 1};
      else if (owed && !rts) begin
         owed <= 0;
         if (!mute) {rxSrc, rxEot, rxAck} <= {frmDest, frmPoll, !frmPoll};
      end
   end
endmodule : hdpm_slave_model

/* dv/test_half_duplex_poll_master.sv */
// self-checking bench for the poll master
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_half_duplex_poll_master;
   typedef struct packed {logic [11:0] a; logic [31:0] d; logic [1:0] w, e; logic [31:0] q;} hdpm_row_t;
   // offset, write data, write answer (3: no write), read answer, read data
   hdpm_row_t rows [7] = '{'{12'h004, 0, 3, 0, 3}, '{12'h010, 0, 3, 0, 10}, '{12'h01C, 0, 3, 0, 1},
      '{12'h000, 255, 2, 0, 0}, '{12'h000, 254, 0, 0, 254}, '{12'h208, 255, 2, 0, 0}, '{12'h030, 1, 2, 2, 0}};
   logic        clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, mute = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, q, rdata;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  r, bresp, rresp;
   logic [7:0]  frmDest, rxSrc;
   logic        awready, wready, bvalid, arready, rvalid, rts, cts, frmStart, frmPoll, txGate;
   logic        frmDone, rxAck, rxEot, rxData, rxReply;
   int          bad_count = 0, cmp_count = 0, cyc = 0, msgs = 0;
   hdpm_master #(.TICK_CYCLES(10)) uut (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rts,
      .cts, .frmStart, .frmPoll, .frmDest, .txGate, .frmDone, .rxAck, .rxEot, .rxData, .rxReply, .rxSrc);
   hdpm_slave_model peer (.clk, .rts, .frmStart, .frmPoll, .txGate, .mute, .frmDest, .cts, .frmDone, .rxAck,
      .rxEot, .rxData, .rxReply, .rxSrc);
   initial forever #2.5 clk = ~clk;
   // cycle ceiling and master message frame count
   always @(posedge clk) begin
      cyc++;
      if (frmStart && !frmPoll) msgs++;
      if (cyc == 50000) begin bad_count++; close_out; end
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
      do @(posedge clk); while (!awready);
      {awvalid, wvalid, bready} <= 3'h1;
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 0;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      {araddr, arvalid} <= {a, 1'h1};
      do @(posedge clk); while (!arready);
      {arvalid, rready} <= 2'h1;
      do @(posedge clk); while (!rvalid);
      {q, r} = {rdata, rresp};
      rready <= 0;
   endtask : rd
   // reads until the masked word matches, bounded
   task automatic poll_rd(input logic [11:0] a, input logic [31:0] m, e);
      repeat (3000) begin rd(a); if ((q & m) === e) break; end
   endtask : poll_rd
   task close_out;
      $display("compared %0d mismatched %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1;
      @(posedge clk);
      foreach (rows[i]) begin
         if (rows[i].w != 3) begin wr(rows[i].a, rows[i].d); `CHK("wresp", rows[i].w, r) end
         rd(rows[i].a);
         `CHK("rdata", rows[i].q, q)
         `CHK("rresp", rows[i].e, r)
      end
      $display("rows done");
      wr(12'h004, 2);
      wr(12'h200, 1);
      wr(12'h208, 5);
      wr(12'h000, 32'h8FE);
      poll_rd(12'h040, 32'h20, 32'h20);
      `CHK("liveness", 32'h20, q)
      // read the offset while a poll is in flight, not in the gap between passes
      @(posedge clk iff (frmStart && frmPoll));
      rd(12'h204);
      `CHK("offset", 32'h1, q)
      $display("poll done");
      mute <= 1;
      msgs = 0;
      wr(12'h020, 7);
      poll_rd(12'h024, 32'h2, 32'h2);
      `CHK("sends", 3, msgs)
      poll_rd(12'h040, 32'h20, 0);
      `CHK("liveness", 0, q)
      $display("retry done");
      resetn <= 0;
      @(posedge clk);
      resetn <= 1;
      repeat (2) @(posedge clk);
      rd(12'h004);
      `CHK("retry reset", 32'h3, q)
      rd(12'h040);
      `CHK("live reset", 0, q)
      $display("reset done");
      // message-based mode: ack, reply poll to the message's station, reply limit 0 expires
      mute <= 0;
      msgs = 0;
      wr(12'h200, 1);
      wr(12'h208, 5);
      wr(12'h000, 32'hAFE);
      wr(12'h020, 7);
      poll_rd(12'h040, 32'h80, 32'h80);
      `CHK("liveness", 32'hA0, q)
      rd(12'h024);
      `CHK("status", 32'h4, q)
      `CHK("sends", 1, msgs)
      $display("reply done");
      close_out;
   end
endmodule : test_half_duplex_poll_master
